//--- flash_status_irq.sv
`timescale 1ns/1ps
`default_nettype none
module flash_status_irq (
    input  wire logic                               clk_sys,
    input  wire logic                               rst_n,
    // apb slave
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [flash_status_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                        pwdata,
    input  wire logic [3:0]                         pstrb,
    output logic                                    pready,
    output logic      [31:0]                        prdata,
    output logic                                    pslverr,
    // sequencer side, same clock
    input  wire logic                               seq_busy,
    input  wire logic                               seq_suspended,
    input  wire logic                               cmd_entered,
    input  wire logic                               cmd_updates_lock,
    input  wire logic                               lock_bit_value,
    input  wire logic                               clear_status_cmd,
    input  wire logic                               program_error,
    input  wire logic                               erase_error,
    input  wire logic                               blank_error,
    input  wire logic                               command_error,
    input  wire logic                               busy_block_access,
    input  wire logic                               data_flash_read_in_rom_rewrite,
    // controls toward the sequencer
    output logic                                    cpu_rewrite_enable,
    output logic                                    ew1_mode,
    output logic                                    flash_stop,
    output logic                                    sequence_reset,
    output logic                                    access_data_undefined,
    output logic                                    flash_irq
);
    import flash_status_pkg::*;

    logic        ready_busy_flag;
    logic        to_ready;
    logic        erase_suspended_r;
    logic        program_error_r;
    logic        erase_blank_error_r;
    logic        lock_state_r;
    logic        lock_pending_r;
    logic [7:0]  control_0_r;
    logic [EVT_W-1:0] irq_mask_r;
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic [1:0]  req_flags;
    logic [1:0]  req_set;
    logic [1:0]  req_clr;
    logic [1:0]  req_flags_nxt;
    logic [31:0] rdata_nxt;
    logic        slverr_nxt;
    logic        setup;
    logic        wr_access;
    logic        wr_status;
    logic        wr_control;
    logic        wr_irq_status;
    logic        wr_irq_mask;
    logic        ready_irq_enable;
    logic        access_error_irq_enable;
    logic        command_error_irq_enable;
    logic        any_cmd_error;
    logic        access_hit;
    logic [7:0]  flash_status;
    logic        mapped;

    // ready/busy tracking and busy-to-ready detection
    ready_edge_detect u_ready_edge (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .busy     (seq_busy),
        .ready_r  (ready_busy_flag),
        .to_ready (to_ready)
    );

    // enables live in flash_control_0
    assign ready_irq_enable         = control_0_r[CT_READY_IE];
    assign access_error_irq_enable  = control_0_r[CT_ACC_ERR_IE];
    assign command_error_irq_enable = control_0_r[CT_CMD_ERR_IE];
    assign cpu_rewrite_enable       = control_0_r[CT_REWRITE_EN];
    assign ew1_mode                 = control_0_r[CT_EW1_MODE];
    // stop only takes effect in rewrite mode
    assign flash_stop = control_0_r[CT_FLASH_STOP] & control_0_r[CT_REWRITE_EN];

    // apb decode
    assign setup     = psel & ~penable;
    assign wr_access = psel & penable & pwrite & pstrb[0];
    assign wr_status     = wr_access & (paddr == FLASH_STATUS_ADDR);
    assign wr_control    = wr_access & (paddr == FLASH_CONTROL_0_ADDR);
    assign wr_irq_status = wr_access & (paddr == IRQ_STATUS_ADDR);
    assign wr_irq_mask   = wr_access & (paddr == IRQ_MASK_ADDR);
    assign mapped = (paddr == FLASH_STATUS_ADDR) | (paddr == FLASH_CONTROL_0_ADDR) |
                    (paddr == IRQ_STATUS_ADDR) | (paddr == IRQ_MASK_ADDR);

    // one wait-free access phase; read data is captured at the setup edge
    assign pready = psel & penable;

    // interrupt request flags: [0] ready, [1] access error
    assign any_cmd_error = command_error | program_error | erase_error | blank_error;
    assign access_hit    = busy_block_access | data_flash_read_in_rom_rewrite;

    always_comb
    begin
        req_set = 2'b00;
        req_clr = 2'b00;
        // busy-to-ready covers every completion the sequencer reports
        req_set[ST_READY_IRQ] = to_ready & ready_irq_enable;
        req_set[ST_ACCESS_ERR] = (access_hit & access_error_irq_enable)
                               | (any_cmd_error & command_error_irq_enable);
        // a written 0 clears, and the clear-status command also clears access error; a written 1 is ignored
        req_clr[ST_READY_IRQ] = wr_status & ~pwdata[ST_READY_IRQ];
        req_clr[ST_ACCESS_ERR] = (wr_status & ~pwdata[ST_ACCESS_ERR])
                               | clear_status_cmd;
    end

    sticky_flags #(
        .W (2)
    ) u_req_flags (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .set     (req_set),
        .clr     (req_clr),
        .q       (req_flags)
    );

    // next flag value, so the line rises and falls in step with the flags
    assign req_flags_nxt = (req_flags & ~req_clr) | req_set;

    // access to a rewriting block yields undefined data and a dropped write
    assign access_data_undefined = access_hit;

    // suspend flag follows the sequencer's acknowledged suspend state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            erase_suspended_r <= 1'b0;
        end
        else
        begin
            erase_suspended_r <= seq_suspended;
        end
    end

    // program error flag: cleared by the clear-status command, set wins
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            program_error_r <= 1'b0;
        end
        else
        begin
            if (program_error || command_error)
            begin
                program_error_r <= 1'b1;
            end
            else if (clear_status_cmd)
            begin
                program_error_r <= 1'b0;
            end
        end
    end

    // erase/blank error flag: same clearing, set wins so no error is lost
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            erase_blank_error_r <= 1'b0;
        end
        else
        begin
            if (erase_error || blank_error || command_error)
            begin
                erase_blank_error_r <= 1'b1;
            end
            else if (clear_status_cmd)
            begin
                erase_blank_error_r <= 1'b0;
            end
        end
    end

    // a command that owns the lock bit arms the reload;
    // a new command entered while armed re-decides it
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_pending_r <= 1'b0;
        end
        else
        begin
            if (cmd_entered)
            begin
                lock_pending_r <= cmd_updates_lock;
            end
            else if (to_ready)
            begin
                lock_pending_r <= 1'b0;
            end
        end
    end

    // undefined after reset, so a constant is chosen
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_state_r <= LOCK_RESET;
        end
        else
        begin
            if (to_ready && lock_pending_r)
            begin
                lock_state_r <= lock_bit_value;
            end
        end
    end

    // flash_control_0; the sequence reset bit is a strobe and reads 0
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control_0_r <= CONTROL_0_RESET;
        end
        else if (wr_control)
        begin
            control_0_r <= pwdata[7:0] & CONTROL_0_WMASK;
        end
    end

    // forced stop is only honoured in rewrite mode while busy
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sequence_reset <= 1'b0;
        end
        else
        begin
            sequence_reset <= wr_control & pwdata[CT_SEQ_RESET]
                            & control_0_r[CT_REWRITE_EN] & ~ready_busy_flag;
        end
    end

    // system interrupt: sticky events, write one to clear, with a mask
    always_comb
    begin
        evt_set = '0;
        evt_set[EV_READY]     = req_set[ST_READY_IRQ];
        evt_set[EV_ACCESS]    = req_set[ST_ACCESS_ERR];
        evt_set[EV_CMD_ERROR] = any_cmd_error;
        evt_set[EV_SUSPEND]   = seq_suspended & ~erase_suspended_r;
        evt_clr = wr_irq_status ? pwdata[EVT_W-1:0] : '0;
    end

    sticky_flags #(
        .W (EVT_W)
    ) u_irq_status (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .set     (evt_set),
        .clr     (evt_clr),
        .q       (irq_status)
    );

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_mask_r <= MASK_RESET;
        end
        else if (wr_irq_mask)
        begin
            irq_mask_r <= pwdata[EVT_W-1:0];
        end
    end

    // request flags always raise the line; the mask only adds optional events
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flash_irq <= 1'b0;
        end
        else
        begin
            flash_irq <= (|req_flags_nxt)
                       | (|(irq_status & irq_mask_r));
        end
    end

    // status view
    always_comb
    begin
        flash_status = 8'h00;
        flash_status[ST_READY_IRQ]  = req_flags[ST_READY_IRQ];
        flash_status[ST_ACCESS_ERR] = req_flags[ST_ACCESS_ERR];
        flash_status[ST_LOCK]       = lock_state_r;
        flash_status[ST_PROG_ERR]   = program_error_r;
        flash_status[ST_ERASE_ERR]  = erase_blank_error_r;
        flash_status[ST_SUSPENDED]  = erase_suspended_r;
        flash_status[ST_READY_BUSY] = ready_busy_flag;
    end

    always_comb
    begin
        rdata_nxt  = READ_ZERO;
        slverr_nxt = 1'b0;
        case (paddr)
            FLASH_STATUS_ADDR:
            begin
                rdata_nxt[7:0] = flash_status;
            end
            FLASH_CONTROL_0_ADDR:
            begin
                rdata_nxt[7:0] = control_0_r;
            end
            IRQ_STATUS_ADDR:
            begin
                rdata_nxt[EVT_W-1:0] = irq_status;
            end
            IRQ_MASK_ADDR:
            begin
                rdata_nxt[EVT_W-1:0] = irq_mask_r;
            end
            default:
            begin
                slverr_nxt = ~mapped;
            end
        endcase
    end

    // read data held for the whole access phase
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata  <= READ_ZERO;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= pwrite ? READ_ZERO : rdata_nxt;
            pslverr <= slverr_nxt;
        end
    end
endmodule
`default_nettype wire

//--- flash_status_pkg.sv
// Operation
// - ready/busy flag reads 0 while the sequencer is busy, 1 otherwise and after reset.
// - ready request flag is set on busy-to-ready only while its enable is 1.
// - completion, suspend, forced stop, lock ops, blank check, wake-up all count as ready.
// - writing 1 to the ready request flag does nothing; writing 0 clears it.
// - access to the busy block sets the access error flag when its enable is 1.
// - data-flash read during program-ROM rewrite also sets the access error flag.
// - command, erase, blank-check or program errors set it when error enable is 1.
// - access error flag clears on write 0 or clear-status command; software never sets it.
// - lock state flag is read-only, 0 locked, 1 not locked.
// - lock state reloads when a program, erase or lock read returns to ready.
// - program error flag is read-only and set on a program error.
// - erase/blank error flag is read-only and set on erase or blank-check error.
// - a command error sets both the program and erase/blank error flags.
// - erase suspended flag is 1 only while suspend is entered.
// - unassigned status bit b3 always reads 0.
// - control bits b7, b6, b5 hold ready, access error and error interrupt enables.
package flash_status_pkg;

    localparam int ADDR_W = 14;
    localparam int EVT_W  = 4;

    // printed offsets are word indexes; byte address is four times the index
    localparam logic [ADDR_W-1:0] FLASH_STATUS_IDX    = 14'h01B2;
    localparam logic [ADDR_W-1:0] FLASH_CONTROL_0_IDX = 14'h01B4;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_IDX      = 14'h01C0;
    localparam logic [ADDR_W-1:0] IRQ_MASK_IDX        = 14'h01C1;

    localparam logic [ADDR_W-1:0] FLASH_STATUS_ADDR    = 14'(FLASH_STATUS_IDX * 4);
    localparam logic [ADDR_W-1:0] FLASH_CONTROL_0_ADDR = 14'(FLASH_CONTROL_0_IDX * 4);
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR      = 14'(IRQ_STATUS_IDX * 4);
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR        = 14'(IRQ_MASK_IDX * 4);

    // flash_status bit positions
    localparam int ST_READY_IRQ   = 0;
    localparam int ST_ACCESS_ERR  = 1;
    localparam int ST_LOCK        = 2;
    localparam int ST_PROG_ERR    = 4;
    localparam int ST_ERASE_ERR   = 5;
    localparam int ST_SUSPENDED   = 6;
    localparam int ST_READY_BUSY  = 7;

    // flash_control_0 bit positions
    localparam int CT_REWRITE_EN  = 1;
    localparam int CT_EW1_MODE    = 2;
    localparam int CT_FLASH_STOP  = 3;
    localparam int CT_SEQ_RESET   = 4;
    localparam int CT_CMD_ERR_IE  = 5;
    localparam int CT_ACC_ERR_IE  = 6;
    localparam int CT_READY_IE    = 7;

    // irq_status / irq_mask bit positions
    localparam int EV_READY       = 0;
    localparam int EV_ACCESS      = 1;
    localparam int EV_CMD_ERROR   = 2;
    localparam int EV_SUSPEND     = 3;

    localparam logic [7:0] CONTROL_0_RESET = 8'h00;
    localparam logic [7:0] CONTROL_0_WMASK = 8'hEF;
    localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;
    localparam logic       LOCK_RESET      = 1'b1;
    localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

endpackage

//--- sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);
    // a set in the same cycle as a clear wins, so no event is lost
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= (q & ~clr) | set;
        end
    end
endmodule
`default_nettype wire

//--- ready_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module ready_edge_detect (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic busy,
    output logic      ready_r,
    output logic      to_ready
);
    logic busy_r;

    // ready after reset: an idle sequencer must not fire a spurious edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
        end
        else
        begin
            busy_r <= busy;
        end
    end

    assign ready_r  = ~busy_r;
    assign to_ready = busy_r & ~busy;
endmodule
`default_nettype wire

//--- flash_status_irq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module flash_status_irq_checker
    import flash_status_pkg::*;
(
    input wire logic                                clk_sys,
    input wire logic                                rst_n,
    input wire logic                                psel,
    input wire logic                                penable,
    input wire logic                                pwrite,
    input wire logic [flash_status_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                         pwdata,
    input wire logic [3:0]                          pstrb,
    input wire logic [31:0]                         prdata,
    input wire logic                                seq_busy,
    input wire logic                                seq_suspended,
    input wire logic                                command_error,
    input wire logic                                busy_block_access,
    input wire logic                                data_flash_read_in_rom_rewrite,
    input wire logic                                access_data_undefined,
    input wire logic                                flash_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // shadow of the three enables, so the checker needs no internal probes
    logic [2:0] ie_r;
    logic       wr;
    logic       rd_s;
    logic       quiet;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign rd_s = psel && !penable && !pwrite && paddr == FLASH_STATUS_ADDR;
    assign quiet = !command_error && !busy_block_access && !data_flash_read_in_rom_rewrite;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ie_r <= 3'h0;
        else if (wr && paddr == FLASH_CONTROL_0_ADDR)
            ie_r <= pwdata[7:5];
    end

    property p_status_rd;
        rd_s |=> prdata[7] == !$past(seq_busy, 2) && prdata[6] == $past(seq_suspended, 2);
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("ready or suspend bit wrong");
    property p_unassigned;
        rd_s |=> prdata[3] == 1'b0 && prdata[31:8] == 24'h0;
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("unassigned bits not zero");
    property p_ready_irq;
        $fell(seq_busy) && ie_r[2] |-> ##[1:2] flash_irq;
    endproperty
    a_ready_irq: assert property (p_ready_irq) else $error("no irq on ready");
    property p_acc_irq;
        busy_block_access && ie_r[1] |-> ##[1:2] flash_irq;
    endproperty
    a_acc_irq: assert property (p_acc_irq) else $error("no irq on access");
    property p_dflash_irq;
        data_flash_read_in_rom_rewrite && ie_r[1] |-> ##[1:2] flash_irq;
    endproperty
    a_dflash_irq: assert property (p_dflash_irq) else $error("no irq on data read");
    property p_cmd_irq;
        command_error && ie_r[0] |-> ##[1:2] flash_irq;
    endproperty
    a_cmd_irq: assert property (p_cmd_irq) else $error("no irq on command error");
    property p_w1_ignored;
        wr && paddr == FLASH_STATUS_ADDR && pwdata[1:0] == 2'h3 && !flash_irq && quiet
            && !$fell(seq_busy) && !$rose(seq_suspended) |=> !flash_irq;
    endproperty
    a_w1_ignored: assert property (p_w1_ignored) else $error("software set a flag");
    property p_undefined;
        access_data_undefined == (busy_block_access || data_flash_read_in_rom_rewrite);
    endproperty
    a_undefined: assert property (p_undefined) else $error("undefined marker wrong");

    c_ready: cover property ($fell(seq_busy) && ie_r[2]);
    c_acc: cover property (busy_block_access && ie_r[1]);
    c_status_wr: cover property (wr && paddr == FLASH_STATUS_ADDR);
endmodule
bind flash_status_irq flash_status_irq_checker u_chk (.clk_sys, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .seq_busy, .seq_suspended, .command_error,
    .busy_block_access, .data_flash_read_in_rom_rewrite, .access_data_undefined, .flash_irq);
`default_nettype wire

//--- test_flash_status_irq.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_status_irq;
    import flash_status_pkg::*;
    logic              clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, got;
    logic [3:0]        pstrb, strb_v;
    logic              seq_busy, seq_suspended, cmd_updates_lock, lock_bit_value;
    logic [7:0]        ev;
    logic              access_data_undefined, flash_irq;
    logic              rw_en, ew1, stop, seq_rst;
    logic [31:0]       exp_e [4];
    int                n_errors, comparisons, cyc;

    flash_status_irq dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .pready, .prdata, .pslverr, .seq_busy, .seq_suspended,
        .cmd_entered(ev[6]), .cmd_updates_lock, .lock_bit_value,
        .clear_status_cmd(ev[7]), .program_error(ev[0]), .erase_error(ev[1]),
        .blank_error(ev[2]), .command_error(ev[3]), .busy_block_access(ev[4]),
        .data_flash_read_in_rom_rewrite(ev[5]), .cpu_rewrite_enable(rw_en), .ew1_mode(ew1),
        .flash_stop(stop), .sequence_reset(seq_rst), .access_data_undefined, .flash_irq);

    task automatic close_out;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // zero wait states today, but the wait stays open-ended up to a bound
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb_v;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        got = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            chk("pready", 32'h1, 32'h0);
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, got);
    endtask

    task automatic irq(input logic e);
        #1;
        chk("flash_irq", {31'h0, e}, {31'h0, flash_irq});
    endtask

    task automatic pulse(input logic [7:0] v);
        @(posedge clk_sys);
        ev <= v;
        @(posedge clk_sys);
        ev <= 8'h00;
    endtask

    task automatic bsy;
        @(posedge clk_sys);
        seq_busy <= 1'b1;
        repeat (3) @(posedge clk_sys);
        seq_busy <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial
    begin
        cyc = 0;
        forever
        begin
            @(posedge clk_sys);
            cyc++;
            if (cyc > 5000)
            begin
                n_errors++;
                close_out();
            end
        end
    end

    initial
    begin
        {rst_n, psel, penable, pwrite, seq_busy, seq_suspended} = 6'h00;
        {cmd_updates_lock, lock_bit_value} = 2'h0;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        strb_v = 4'hF;
        ev = 8'h00;
        exp_e = '{32'h96, 32'hA6, 32'hA6, 32'hB6};
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdc(FLASH_STATUS_ADDR, 32'h84, "status reset");
        rdc(FLASH_CONTROL_0_ADDR, 32'h00, "control reset");
        rdc(IRQ_MASK_ADDR, 32'h00, "mask reset");
        apb(1'b0, 14'h0004, 32'h0);
        chk("unmapped slverr", 32'h1, {31'h0, err});
        seq_busy <= 1'b1;
        rdc(FLASH_STATUS_ADDR, 32'h04, "status busy");
        seq_busy <= 1'b0;
        rdc(FLASH_STATUS_ADDR, 32'h84, "ready no enable");
        irq(1'b0);
        apb(1'b1, FLASH_CONTROL_0_ADDR, 32'h82);
        bsy();
        rdc(FLASH_STATUS_ADDR, 32'h85, "ready request");
        irq(1'b1);
        apb(1'b1, FLASH_STATUS_ADDR, 32'hFF);
        rdc(FLASH_STATUS_ADDR, 32'h85, "write ones");
        apb(1'b1, FLASH_STATUS_ADDR, 32'h00);
        rdc(FLASH_STATUS_ADDR, 32'h84, "ready cleared");
        irq(1'b0);
        // suspend drives both the status bit and the masked event path
        apb(1'b1, IRQ_MASK_ADDR, 32'h08);
        seq_suspended <= 1'b1;
        rdc(FLASH_STATUS_ADDR, 32'hC4, "suspended");
        irq(1'b1);
        // the ready event from the first enabled busy cycle is still latched
        rdc(IRQ_STATUS_ADDR, 32'h09, "event status");
        apb(1'b1, IRQ_STATUS_ADDR, 32'h08);
        // the masked event path reaches the line one cycle after the clear
        @(posedge clk_sys);
        irq(1'b0);
        seq_suspended <= 1'b0;
        rdc(FLASH_STATUS_ADDR, 32'h84, "suspend left");
        apb(1'b1, IRQ_MASK_ADDR, 32'h00);
        apb(1'b1, FLASH_CONTROL_0_ADDR, 32'h02);
        cmd_updates_lock <= 1'b1;
        pulse(8'h40);
        bsy();
        rdc(FLASH_STATUS_ADDR, 32'h80, "locked");
        cmd_updates_lock <= 1'b0;
        lock_bit_value <= 1'b1;
        pulse(8'h40);
        bsy();
        rdc(FLASH_STATUS_ADDR, 32'h80, "lock kept");
        cmd_updates_lock <= 1'b1;
        pulse(8'h40);
        bsy();
        rdc(FLASH_STATUS_ADDR, 32'h84, "unlocked");
        apb(1'b1, FLASH_CONTROL_0_ADDR, 32'h22);
        for (int i = 0; i < 4; i++)
        begin
            pulse(8'h01 << i);
            rdc(FLASH_STATUS_ADDR, exp_e[i], "error flags");
            irq(1'b1);
            pulse(8'h80);
            rdc(FLASH_STATUS_ADDR, 32'h84, "clear status");
            irq(1'b0);
        end
        apb(1'b1, FLASH_CONTROL_0_ADDR, 32'h02);
        pulse(8'h08);
        rdc(FLASH_STATUS_ADDR, 32'hB4, "error no enable");
        irq(1'b0);
        pulse(8'h80);
        apb(1'b1, FLASH_CONTROL_0_ADDR, 32'h42);
        pulse(8'h10);
        rdc(FLASH_STATUS_ADDR, 32'h86, "busy access");
        irq(1'b1);
        apb(1'b1, FLASH_STATUS_ADDR, 32'h01);
        rdc(FLASH_STATUS_ADDR, 32'h84, "access cleared");
        pulse(8'h20);
        rdc(FLASH_STATUS_ADDR, 32'h86, "data flash read");
        apb(1'b1, FLASH_STATUS_ADDR, 32'h00);
        apb(1'b1, FLASH_CONTROL_0_ADDR, 32'h02);
        pulse(8'h30);
        rdc(FLASH_STATUS_ADDR, 32'h84, "access no enable");
        apb(1'b1, FLASH_STATUS_ADDR, 32'h03);
        rdc(FLASH_STATUS_ADDR, 32'h84, "no software set");
        irq(1'b0);
        strb_v = 4'h0;
        apb(1'b1, FLASH_CONTROL_0_ADDR, 32'h80);
        strb_v = 4'hF;
        rdc(FLASH_CONTROL_0_ADDR, 32'h02, "strobe off");
        // forced stop while busy in rewrite mode, plus the plain control outputs
        seq_busy <= 1'b1;
        apb(1'b1, FLASH_CONTROL_0_ADDR, 32'h1E);
        #1;
        chk("control outputs", 32'h0F, {28'h0, seq_rst, stop, ew1, rw_en});
        @(posedge clk_sys);
        seq_busy <= 1'b0;
        rdc(FLASH_CONTROL_0_ADDR, 32'h0E, "control readback");
        chk("sequence_reset pulse", 32'h0, {31'h0, seq_rst});
        // both request flags are clear here, so rewrite mode may be left
        apb(1'b1, FLASH_CONTROL_0_ADDR, 32'h00);
        close_out();
    end
endmodule
`default_nettype wire
